// ### src/ssc_pkg.sv
// Package: status word layout, reset values and checksum constants
package ssc_pkg;
    // Status word bit positions
    localparam int SSC_BIT_ALERT = 15;
    localparam int SSC_BIT_HEATER = 13;
    localparam int SSC_BIT_RH_ALERT = 11;
    localparam int SSC_BIT_T_ALERT = 10;
    localparam int SSC_BIT_RESET = 4;
    localparam int SSC_BIT_CMD_FAIL = 1;
    localparam int SSC_BIT_WR_CRC_FAIL = 0;
    // Values after reset
    localparam logic SSC_RST_ALERT = 1'b1;
    localparam logic SSC_RST_HEATER = 1'b0;
    localparam logic SSC_RST_TRACK = 1'b0;
    localparam logic SSC_RST_RESET = 1'b1;
    localparam logic SSC_RST_CMD_FAIL = 1'b0;
    localparam logic SSC_RST_WR_CRC_FAIL = 1'b0;
    localparam logic [4:0] SSC_RSVD_9_5 = 5'h00;
    // Whole status word after reset: alert pending and reset detected
    localparam logic [15:0] SSC_RST_STATUS = 16'h8010;
    // Checksum parameters
    localparam logic [7:0] SSC_CRC_POLY = 8'h31;
    localparam logic [7:0] SSC_CRC_INIT = 8'hFF;
    localparam logic [7:0] SSC_CRC_XOROUT = 8'h00;
    // Cycles for a checksum unit to finish one word
    localparam int SSC_CRC_LATENCY = 1;

    // Data word with its checksum byte
    typedef struct packed {
        logic [15:0] word;
        logic [7:0] crc;
    } ssc_frame_t;

    // Events from the device core
    typedef struct packed {
        logic hard_reset;
        logic soft_reset;
        logic supply_fail;
        logic rh_alert;
        logic t_alert;
        logic heater_on;
        logic clear_status;
        logic cmd_done;
        logic cmd_ok;
        logic wr_done;
    } ssc_events_t;
endpackage

// ### src/ssc_crc8.sv
// CRC-8 over one 16-bit word, registered result
`timescale 1ns/10ps
`default_nettype none
module ssc_crc8 (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] word,
    output logic [7:0] crc
);
    import ssc_pkg::*;

    // Bitwise MSB-first CRC, poly 0x31, init 0xFF, no reflection
    function automatic logic [7:0] crc_word(input logic [15:0] w);
        logic [7:0] c;
        c = SSC_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ w[i]) begin
                c = {c[6:0], 1'b0} ^ SSC_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c ^ SSC_CRC_XOROUT;
    endfunction

    // Result over exactly the two bytes given
    always_ff @(posedge clk) begin
        if (reset) begin
            crc <= 8'h00;
        end else begin
            crc <= crc_word(word);
        end
    end
endmodule
`default_nettype wire

// ### src/ssc_status.sv
// Status word, flag logic and word checksums of the sensor
// Function
// - Bit 15 shows pending alert; reads 1 after reset.
// - Bit 13 shows heater on; defaults to 0.
// - Bits 11 and 10 show humidity and temperature tracking alerts.
// - Bit 4 set by any reset or supply fail, held until clear.
// - Bit 1 set when last command rejected, cleared on success.
// - Bit 0 set when last write checksum wrong, cleared when right.
// - Clear command zeroes bits 15, 11, 10, 4 only.
// - Checksum follows every word, over its two bytes only.
// - CRC-8 poly 0x31, init 0xFF, no reflection, xor 0x00.
// - Checksum generated on reads and verified on writes.
// - Results leave as 16-bit unsigned raw codes, passed on uncompensated.
`timescale 1ns/10ps
`default_nettype none
module ssc_status (
    input wire logic clk,
    input wire logic reset,
    input wire ssc_pkg::ssc_events_t events,
    input wire logic [15:0] raw_humidity_code,
    input wire logic [15:0] wr_word,
    input wire logic [7:0] wr_crc,
    output logic [15:0] status_word,
    output ssc_pkg::ssc_frame_t status_frame,
    output ssc_pkg::ssc_frame_t humidity_frame,
    output logic wr_crc_ok
);
    import ssc_pkg::*;

    logic alert_q;
    logic heater_q;
    logic rh_alert_q;
    logic t_alert_q;
    logic reset_seen_q;
    logic cmd_fail_q;
    logic wr_fail_q;
    logic [15:0] status_d;
    logic [7:0] status_crc;
    logic [7:0] hum_crc;
    logic [7:0] wr_calc;
    logic [15:0] status_word_q;
    logic [15:0] hum_word_q;
    logic wr_done_q;
    logic [7:0] wr_crc_q;

    // Tracking alerts; a new alert wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            rh_alert_q <= SSC_RST_TRACK;
            t_alert_q <= SSC_RST_TRACK;
        end else begin
            if (events.rh_alert) begin
                rh_alert_q <= 1'b1;
            end else if (events.clear_status) begin
                rh_alert_q <= 1'b0;
            end
            if (events.t_alert) begin
                t_alert_q <= 1'b1;
            end else if (events.clear_status) begin
                t_alert_q <= 1'b0;
            end
        end
    end

    // Alert pending summary flag
    always_ff @(posedge clk) begin
        if (reset) begin
            alert_q <= SSC_RST_ALERT;
        end else if (events.rh_alert || events.t_alert) begin
            alert_q <= 1'b1;
        end else if (events.clear_status) begin
            alert_q <= 1'b0;
        end
    end

    // Reset detected flag
    always_ff @(posedge clk) begin
        if (reset) begin
            reset_seen_q <= SSC_RST_RESET;
        end else if (events.hard_reset || events.soft_reset ||
                     events.supply_fail) begin
            reset_seen_q <= 1'b1;
        end else if (events.clear_status) begin
            reset_seen_q <= 1'b0;
        end
    end

    // Heater state mirror
    always_ff @(posedge clk) begin
        if (reset) begin
            heater_q <= SSC_RST_HEATER;
        end else begin
            heater_q <= events.heater_on;
        end
    end

    // Command outcome of the latest command
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_fail_q <= SSC_RST_CMD_FAIL;
        end else if (events.cmd_done) begin
            cmd_fail_q <= ~events.cmd_ok;
        end
    end

    // Capture incoming write checksum and done pulse for checking
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_done_q <= 1'b0;
            wr_crc_q <= 8'h00;
        end else begin
            wr_done_q <= events.wr_done;
            wr_crc_q <= wr_crc;
        end
    end

    // Written word checksum verdict of the latest write
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_fail_q <= SSC_RST_WR_CRC_FAIL;
            wr_crc_ok <= 1'b1;
        end else if (wr_done_q) begin
            wr_fail_q <= (wr_calc != wr_crc_q);
            wr_crc_ok <= (wr_calc == wr_crc_q);
        end
    end

    // Assemble status word; reserved bits fixed
    always_comb begin
        status_d = 16'h0000;
        status_d[SSC_BIT_ALERT] = alert_q;
        status_d[SSC_BIT_HEATER] = heater_q;
        status_d[SSC_BIT_RH_ALERT] = rh_alert_q;
        status_d[SSC_BIT_T_ALERT] = t_alert_q;
        status_d[9:5] = SSC_RSVD_9_5;
        status_d[SSC_BIT_RESET] = reset_seen_q;
        status_d[SSC_BIT_CMD_FAIL] = cmd_fail_q;
        status_d[SSC_BIT_WR_CRC_FAIL] = wr_fail_q;
    end

    // Register status word and measurement word
    always_ff @(posedge clk) begin
        if (reset) begin
            status_word_q <= SSC_RST_STATUS;
            hum_word_q <= 16'h0000;
        end else begin
            status_word_q <= status_d;
            hum_word_q <= raw_humidity_code;
        end
    end

    // Status output register
    always_ff @(posedge clk) begin
        if (reset) begin
            status_word <= SSC_RST_STATUS;
        end else begin
            status_word <= status_d;
        end
    end

    // Frames: word MSB first then its checksum, aligned with crc delay
    always_ff @(posedge clk) begin
        if (reset) begin
            status_frame <= '0;
            humidity_frame <= '0;
        end else begin
            status_frame <= '{word: status_word_q, crc: status_crc};
            humidity_frame <= '{word: hum_word_q, crc: hum_crc};
        end
    end

    // Checksum units: outgoing status, outgoing humidity, incoming write
    ssc_crc8 u_crc_status (
        .clk(clk),
        .reset(reset),
        .word(status_d),
        .crc(status_crc)
    );
    ssc_crc8 u_crc_hum (
        .clk(clk),
        .reset(reset),
        .word(raw_humidity_code),
        .crc(hum_crc)
    );
    ssc_crc8 u_crc_wr (
        .clk(clk),
        .reset(reset),
        .word(wr_word),
        .crc(wr_calc)
    );
endmodule
`default_nettype wire

// ### dv/ssc_status_sva.sv
// Checker: status flag timing and reserved bits
`timescale 1ns/10ps
`default_nettype none
module ssc_status_sva (
    input wire logic clk,
    input wire logic reset,
    input wire ssc_pkg::ssc_events_t events,
    input wire logic [15:0] status_word,
    input wire logic wr_crc_ok
);
    import ssc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // A set event in the clear cycle wins
    wire logic set_any = events.hard_reset | events.soft_reset
        | events.supply_fail | events.rh_alert | events.t_alert;
    property p_rsvd;
        (status_word & 16'h53EC) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_heat;
        status_word[13] == $past(events.heater_on, 2);
    endproperty
    a_heat: assert property (p_heat) else $error("heater bit");
    property p_rh;
        events.rh_alert |-> ##2 status_word[11] && status_word[15];
    endproperty
    a_rh: assert property (p_rh) else $error("humidity alert");
    property p_t;
        events.t_alert |-> ##2 status_word[10] && status_word[15];
    endproperty
    a_t: assert property (p_t) else $error("temperature alert");
    property p_rbit;
        events.hard_reset || events.soft_reset || events.supply_fail
            |-> ##2 status_word[4];
    endproperty
    a_rbit: assert property (p_rbit) else $error("reset bit");
    property p_clr;
        events.clear_status && !set_any |-> ##2
            (status_word & 16'h8C10) == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_cmd;
        events.cmd_done |-> ##2 status_word[1] == !$past(events.cmd_ok, 2);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command bit");
    property p_wr;
        !$past(events.wr_done, 2) |-> $stable(wr_crc_ok);
    endproperty
    a_wr: assert property (p_wr) else $error("write verdict moved");
    c_clr: cover property (events.clear_status);
    c_cmd: cover property (events.cmd_done && !events.cmd_ok);
    c_wr: cover property (events.wr_done ##2 !wr_crc_ok);
endmodule
bind ssc_status ssc_status_sva chk_u (.clk(clk), .reset(reset),
    .events(events), .status_word(status_word), .wr_crc_ok(wr_crc_ok));
`default_nettype wire

// ### dv/ssc_host_model.sv
// Host model: frame check, write checksum, humidity scaling
`timescale 1ns/10ps
`default_nettype none
module ssc_host_model (
    input wire ssc_pkg::ssc_frame_t rx_frame,
    input wire logic [15:0] tx_word,
    input wire logic tx_bad,
    output logic rx_ok,
    output logic [7:0] tx_crc,
    output logic [7:0] rh_pct
);
    import ssc_pkg::*;
    // Bitwise CRC over the two bytes, MSB first
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        end
        return c;
    endfunction
    // Receiver verifies, sender appends; tx_bad spoils it on purpose
    assign rx_ok = (crc8(rx_frame.word) == rx_frame.crc);
    assign tx_crc = crc8(tx_word) ^ {7'h00, tx_bad};
    // Humidity in whole percent
    assign rh_pct = 8'((32'(rx_frame.word) * 100) / 65535);
endmodule
`default_nettype wire

// ### dv/sensor_status_and_crc_tb.sv
// Testbench: status flags, write verdict and frame checksums
`timescale 1ns/10ps
`default_nettype none
module sensor_status_and_crc_tb;
    import ssc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] pulse = 10'h000;
    logic heater = 1'b0;
    logic sel = 1'b0;
    logic bad = 1'b0;
    logic [15:0] raw = 16'h0000;
    logic [15:0] wr_word = 16'h1234;
    logic [7:0] wr_crc, rh_pct;
    logic [15:0] status_word;
    ssc_frame_t status_frame, humidity_frame;
    logic wr_crc_ok, rx_ok;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    wire ssc_events_t events = ssc_events_t'(pulse | {5'h00, heater, 4'h0});
    always #4 clk = ~clk;
    ssc_status dut_u (.clk(clk), .reset(reset), .events(events),
        .raw_humidity_code(raw), .wr_word(wr_word), .wr_crc(wr_crc),
        .status_word(status_word), .status_frame(status_frame),
        .humidity_frame(humidity_frame), .wr_crc_ok(wr_crc_ok));
    ssc_host_model host_u (.rx_frame(sel ? status_frame : humidity_frame),
        .tx_word(wr_word), .tx_bad(bad), .rx_ok(rx_ok), .tx_crc(wr_crc),
        .rh_pct(rh_pct));
    task chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One event pulse, then time for the status word to settle
    task step(input logic [9:0] e);
        @(posedge clk) pulse <= e;
        @(posedge clk) pulse <= 10'h000;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task t_reset;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(status_word, 16'h8010);
        chk(wr_crc_ok, 1'b1);
        sel = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(rx_ok, 1'b1);
    endtask
    task t_resets;
        static logic [9:0] src [3] = '{10'h200, 10'h100, 10'h080};
        for (int i = 0; i < 3; i++) begin
            step(10'h008);
            chk(status_word, 16'h0000);
            step(src[i]);
            chk(status_word, 16'h0010);
        end
    endtask
    task t_alerts;
        step(10'h040);
        chk(status_word, 16'h8810);
        step(10'h020);
        chk(status_word, 16'h8C10);
        @(posedge clk) heater <= 1'b1;
        step(10'h004);
        chk(status_word, 16'hAC12);
        step(10'h008);
        chk(status_word, 16'h2002);
        step(10'h006);
        chk(status_word, 16'h2000);
        @(posedge clk) heater <= 1'b0;
        step(10'h000);
        chk(status_word, 16'h0000);
    endtask
    task t_write;
        @(posedge clk) bad <= 1'b1;
        step(10'h001);
        chk(status_word, 16'h0001);
        chk(wr_crc_ok, 1'b0);
        @(posedge clk) bad <= 1'b0;
        step(10'h001);
        chk(status_word, 16'h0000);
        chk(wr_crc_ok, 1'b1);
    endtask
    task t_frames;
        @(posedge clk) raw <= 16'hBEEF;
        sel = 1'b0;
        step(10'h000);
        chk(humidity_frame, 24'hBEEF92);
        @(posedge clk) raw <= 16'hFFFF;
        step(10'h000);
        chk(rx_ok, 1'b1);
        chk(rh_pct, 8'h64);
        sel = 1'b1;
        #1;
        chk(rx_ok, 1'b1);
    endtask
    // Second reset in mid-run brings back the power-up word
    task t_rerun;
        @(posedge clk) reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(status_word, 16'h8010);
        chk(wr_crc_ok, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        chk(rx_ok, 1'b1);
        chk(status_frame.word, 16'h8010);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        t_reset();
        t_resets();
        t_alerts();
        t_write();
        t_frames();
        t_rerun();
        results();
    end
endmodule
`default_nettype wire
